// ==== dbp_dual_port.v ====
// Top of the dual byte bidirectional port: address decode, reset causes,
// wake detection and read data.
// Assumes a core on the same instruction clock drives the access strobes.
//
// How it works
// RL1: Sixteen lines, data latches at 12H, 14H.
// RL2: Reads sample pad level, no input latch.
// RL3: Written output data holds until rewritten.
// RL4: Per-line direction bit, changeable any time.
// RL5: Direction one is input; zero drives latch.
// RL6: Read returns pad for inputs, latch otherwise.
// RL7: Outputs are push-pull only.
// RL8: Direction registers at 13H and 15H.
// RL9: All ones on qualifying resets; halt timeout keeps.
// RL10: After reset every line is input.
// RL11: Single bit set and clear on latches.
// RL12: Read-modify-write uses direction-dependent read source.
// RL13: Port A lines wake from halt, optional.
// RL14: Optional pull-ups on all lines.
// RL15: Output enable registered inverse of direction.
`timescale 1ns/1ps
`include "dbp_map.vh"
module dbp_dual_port #(
    parameter       W            = `DBP_PORT_W,
    parameter       AW           = `DBP_ADDR_W,
    parameter [0:0] WAKE_OPTION  = 1'b1,
    parameter [0:0] PULLUP_A     = 1'b1,
    parameter [0:0] PULLUP_B     = 1'b1
) (
    input  wire          clock,
    input  wire          reset_n,
    input  wire          clock_enable,
    input  wire          power_on_reset,
    input  wire          watchdog_timeout,
    input  wire          external_reset_pin,
    input  wire          halted,
    input  wire [AW-1:0] address,
    input  wire          write_strobe,
    input  wire          read_strobe,
    input  wire [1:0]    write_op,
    input  wire [2:0]    bit_index,
    input  wire [W-1:0]  write_data,
    output reg  [W-1:0]  read_data,
    output wire          read_hit,
    input  wire [W-1:0]  pin_a_in,
    output wire [W-1:0]  pin_a_out,
    output wire [W-1:0]  pin_a_oe,
    output wire [W-1:0]  pull_up_a,
    input  wire [W-1:0]  pin_b_in,
    output wire [W-1:0]  pin_b_out,
    output wire [W-1:0]  pin_b_oe,
    output wire [W-1:0]  pull_up_b,
    output reg           wake_request
);
    wire [W-1:0] pad_a;
    wire [W-1:0] pad_b;
    wire [W-1:0] read_a;
    wire [W-1:0] read_b;
    wire [W-1:0] latch_a;
    wire [W-1:0] latch_b;
    wire [W-1:0] dir_a;
    wire [W-1:0] dir_b;
    wire         soft_reset;
    reg  [W-1:0] pad_a_prev;
    reg  [W-1:0] next_read;

    // Decode helper for the four mapped locations
    function hit;
        input [AW-1:0] a;
        input [AW-1:0] target;
        begin
            hit = (a == target);
        end
    endfunction

    // Reset causes; watchdog while halted leaves ports alone
    assign soft_reset = power_on_reset
                      | (watchdog_timeout & ~halted)
                      | external_reset_pin; // [RL9]

    assign read_hit = read_strobe & (hit(address, `DBP_ADDR_PORT_A) | hit(address, `DBP_ADDR_DIR_A)
                    | hit(address, `DBP_ADDR_PORT_B) | hit(address, `DBP_ADDR_DIR_B));

    // Fabrication-time pull-up option per port
    assign pull_up_a = {W{PULLUP_A}}; // [RL14]
    assign pull_up_b = {W{PULLUP_B}}; // [RL14]

    // Pad synchronisers
    dbp_sync #(.W(W)) u_sync_a (
        .clock        (clock),
        .reset_n      (reset_n),
        .clock_enable (clock_enable),
        .async_in     (pin_a_in),
        .sync_out     (pad_a)
    );

    dbp_sync #(.W(W)) u_sync_b (
        .clock        (clock),
        .reset_n      (reset_n),
        .clock_enable (clock_enable),
        .async_in     (pin_b_in),
        .sync_out     (pad_b)
    );

    // Port A at 12H/13H
    dbp_port_lane #(.W(W)) u_lane_a (
        .clock        (clock),
        .reset_n      (reset_n),
        .clock_enable (clock_enable),
        .soft_reset   (soft_reset),
        .data_write   (write_strobe & hit(address, `DBP_ADDR_PORT_A)), // [RL1]
        .dir_write    (write_strobe & hit(address, `DBP_ADDR_DIR_A)),  // [RL8]
        .write_op     (write_op),
        .bit_index    (bit_index),
        .write_data   (write_data),
        .pad_sync     (pad_a),
        .data_latch   (latch_a),
        .direction    (dir_a),
        .port_read    (read_a),
        .pin_out      (pin_a_out),
        .pin_oe       (pin_a_oe)
    );

    // Port B at 14H/15H
    dbp_port_lane #(.W(W)) u_lane_b (
        .clock        (clock),
        .reset_n      (reset_n),
        .clock_enable (clock_enable),
        .soft_reset   (soft_reset),
        .data_write   (write_strobe & hit(address, `DBP_ADDR_PORT_B)), // [RL1]
        .dir_write    (write_strobe & hit(address, `DBP_ADDR_DIR_B)),  // [RL8]
        .write_op     (write_op),
        .bit_index    (bit_index),
        .write_data   (write_data),
        .pad_sync     (pad_b),
        .data_latch   (latch_b),
        .direction    (dir_b),
        .port_read    (read_b),
        .pin_out      (pin_b_out),
        .pin_oe       (pin_b_oe)
    );

    // Read mux; unmapped addresses read zero
    always @* begin
        next_read = {W{1'b0}};
        if (hit(address, `DBP_ADDR_PORT_A))
            next_read = read_a; // [RL2] [RL6]
        else if (hit(address, `DBP_ADDR_DIR_A))
            next_read = dir_a;
        else if (hit(address, `DBP_ADDR_PORT_B))
            next_read = read_b; // [RL2] [RL6]
        else if (hit(address, `DBP_ADDR_DIR_B))
            next_read = dir_b;
    end

    // Read data sampled at the strobe edge, held otherwise
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n)
            read_data <= {W{1'b0}};
        else if (clock_enable && read_strobe)
            read_data <= next_read; // [RL2]
    end

    // Wake on any port A input line changing while halted
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            pad_a_prev   <= {W{1'b1}};
            wake_request <= 1'b0;
        end else if (clock_enable) begin
            pad_a_prev   <= pad_a;
            wake_request <= WAKE_OPTION & halted & (|((pad_a ^ pad_a_prev) & dir_a)); // [RL13]
        end
    end
endmodule // dbp_dual_port

// ==== dbp_dual_port_bench.sv ====
// Bench for the dual byte port: access tasks, resets, wake.
// Assumes default design parameters; the checker is bound below.
`timescale 1ns/1ps
module dbp_dual_port_bench;
    logic       clock, reset_n, clock_enable, power_on_reset, watchdog_timeout, external_reset_pin;
    logic       halted, write_strobe, read_strobe, read_hit, wake_request, ext_on, got;
    logic [7:0] address, write_data, read_data, pin_a_in, pin_a_out, pin_a_oe, pull_up_a;
    logic [7:0] pin_b_in, pin_b_out, pin_b_oe, pull_up_b, lat [2], dr [2], ext [2];
    logic [1:0] write_op;
    logic [2:0] bit_index;
    int         errors, checks_done;
    dbp_dual_port dut (.*);
    dbp_pad_model pad_a (.clock, .drv_out(pin_a_out), .drv_oe(pin_a_oe), .pull(pull_up_a),
                         .ext_val(ext[0]), .ext_on, .pad(pin_a_in));
    dbp_pad_model pad_b (.clock, .drv_out(pin_b_out), .drv_oe(pin_b_oe), .pull(pull_up_b),
                         .ext_val(ext[1]), .ext_on, .pad(pin_b_in));
    // Clock at 50 MHz
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [1:0] o, input logic [2:0] b, input logic [7:0] d);
        @(negedge clock);
        {write_strobe, address, write_op, bit_index, write_data} = {1'b1, a, o, b, d};
        @(negedge clock) write_strobe = 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clock);
        {read_strobe, address} = {1'b1, a};
        @(posedge clock) chk({7'h00, read_hit}, {7'h00, a >= 8'h12 && a <= 8'h15});
        @(negedge clock) read_strobe = 1'b0;
        chk(read_data, exp);
    endtask
    // Data access on port p, tracking the expected latch
    task op(input int p, input logic [1:0] o, input logic [2:0] b, input logic [7:0] d);
        logic [7:0] im;
        im = lat[p] & ~dr[p] | ext[p] & dr[p];
        wr(8'h12 + 8'(2 * p), o, b, d);
        case (o)
            2'h0: lat[p] = d;
            2'h1: lat[p] = im | 8'h01 << b;
            2'h2: lat[p] = im & ~(8'h01 << b);
            default: lat[p] = ~im;
        endcase
        repeat (2) @(negedge clock);
        chk(p ? pin_b_out : pin_a_out, lat[p]);
    endtask
    task results;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Main sequence
    initial begin
        {clock_enable, reset_n, ext_on, power_on_reset, watchdog_timeout, external_reset_pin, halted} = 7'h40;
        {write_strobe, read_strobe, address, write_op, bit_index, write_data} = '0;
        {errors, checks_done} = '0;
        lat = '{8'hff, 8'hff};
        dr = lat;
        ext = '{8'h3c, 8'hc3};
        repeat (12) @(negedge clock);
        reset_n = 1'b1;
        for (int a = 8'h12; a < 8'h17; a++) rd(8'(a), a > 8'h15 ? 8'h00 : 8'hff);
        chk(pin_a_oe | pin_b_oe, 8'h00);
        chk(pull_up_a & pull_up_b, 8'hff);
        $display("test reset done");
        ext_on = 1'b1;
        for (int p = 0; p < 2; p++) begin
            wr(8'h13 + 8'(2 * p), 2'h0, 3'h0, 8'h0f);
            dr[p] = 8'h0f;
            op(p, 2'h0, 3'h0, 8'ha5);
            chk(p ? pin_b_oe : pin_a_oe, 8'hf0);
            rd(8'h12 + 8'(2 * p), lat[p] & 8'hf0 | ext[p] & 8'h0f);
            for (int o = 1; o < 4; o++) op(p, 2'(o), 3'(o * 3), 8'h00);
        end
        $display("test ports done");
        for (int c = 4; c >= 0; c--) begin
            wr(8'h13, 2'h0, 3'h0, 8'h00);
            @(negedge clock);
            {power_on_reset, watchdog_timeout, external_reset_pin, halted} = {c == 0, c == 1 || c == 4, c == 2 || c == 3, c > 2};
            @(negedge clock);
            {power_on_reset, watchdog_timeout, external_reset_pin, halted} = 4'h0;
            repeat (2) @(negedge clock);
            chk(pin_a_oe, c == 4 ? 8'hff : 8'h00);
            chk(pin_a_out, c == 4 ? lat[0] : 8'hff);
            rd(8'h15, c == 4 ? dr[1] : 8'hff);
        end
        $display("test resets done");
        // Clock enable low must freeze the direction write
        clock_enable = 1'b0;
        wr(8'h13, 2'h0, 3'h0, 8'h00);
        clock_enable = 1'b1;
        repeat (2) @(negedge clock);
        chk(pin_a_oe, 8'h00);
        rd(8'h13, 8'hff);
        $display("test freeze done");
        halted = 1'b1;
        repeat (4) @(negedge clock);
        ext[0] = ~ext[0];
        got = 1'b0;
        repeat (6) @(negedge clock) got |= wake_request;
        chk({7'h00, got}, 8'h01);
        halted = 1'b0;
        $display("test wake done");
        results;
    end
    // Watchdog; the tests need under 400 cycles
    initial begin
        #50us;
        errors++;
        results;
    end
endmodule // dbp_dual_port_bench

bind dbp_dual_port dbp_dual_port_checker chk_i (.*);

// ==== dbp_dual_port_checker.sv ====
// Assertions on the dual byte port pins and read data.
// Assumes a bind into dbp_dual_port at its default widths.
`timescale 1ns/1ps
module dbp_dual_port_checker (
    input wire       clock,
    input wire       reset_n,
    input wire       clock_enable,
    input wire       power_on_reset,
    input wire       watchdog_timeout,
    input wire       external_reset_pin,
    input wire       halted,
    input wire [7:0] address,
    input wire       write_strobe,
    input wire       read_strobe,
    input wire [1:0] write_op,
    input wire [7:0] write_data,
    input wire [7:0] read_data,
    input wire [7:0] pin_a_out,
    input wire [7:0] pin_a_oe,
    input wire [7:0] pin_b_oe,
    input wire       wake_request
);
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    // Writes no reset cause overrides, soft resets, halted time-outs
    wire ce = clock_enable;
    wire wr = write_strobe & ce & ~(power_on_reset | watchdog_timeout | external_reset_pin);
    wire pw = wr & (write_op == 2'h0);
    wire sr = ce & (power_on_reset | external_reset_pin | watchdog_timeout & ~halted);
    wire hk = ce & watchdog_timeout & halted & ~power_on_reset & ~external_reset_pin & ~write_strobe;
    a_oe_dir_a: assert property (wr && address == 8'h13 ##1 ce |=> pin_a_oe == ~$past(write_data, 2))
        else $error("pin_a_oe wrong");
    a_oe_dir_b: assert property (wr && address == 8'h15 ##1 ce |=> pin_b_oe == ~$past(write_data, 2))
        else $error("pin_b_oe wrong");
    a_out_latch: assert property (pw && address == 8'h12 ##1 ce |=> pin_a_out == $past(write_data, 2))
        else $error("pin_a_out wrong");
    a_reset_ones: assert property (sr ##1 ce |=> pin_a_oe == 8'h00 && pin_b_oe == 8'h00 && pin_a_out == 8'hff)
        else $error("soft reset missed");
    a_halt_keeps: assert property (hk ##1 ce |=> $stable(pin_a_oe) && $stable(pin_b_oe))
        else $error("halted time-out changed port");
    a_unmapped_zero: assert property (read_strobe && ce && (address < 8'h12 || address > 8'h15) |=> read_data == 8'h00)
        else $error("unmapped read not zero");
    a_read_holds: assert property (!(read_strobe && ce) |=> $stable(read_data))
        else $error("read data moved");
    a_wake_halted: assert property (wake_request |-> $past(halted))
        else $error("wake while running");
endmodule // dbp_dual_port_checker

// ==== dbp_map.vh ====
// Address map, field widths and reset values of the dual byte port block.
// Assumes inclusion by bare name from the port modules.
`ifndef DBP_MAP_VH
`define DBP_MAP_VH

`define DBP_ADDR_W          8
`define DBP_PORT_W          8
`define DBP_ADDR_PORT_A     8'h12
`define DBP_ADDR_DIR_A      8'h13
`define DBP_ADDR_PORT_B     8'h14
`define DBP_ADDR_DIR_B      8'h15
`define DBP_RESET_DATA      8'hff
`define DBP_RESET_DIR       8'hff
`define DBP_OP_WRITE        2'h0
`define DBP_OP_SET_BIT      2'h1
`define DBP_OP_CLR_BIT      2'h2
`define DBP_OP_CPL          2'h3

`endif

// ==== dbp_pad_model.sv ====
// Board model of eight pads: port drive, outside driver, pull-ups.
// Assumes one instance per port, fed by that port's pin outputs.
`timescale 1ns/1ps
module dbp_pad_model (
    input  wire       clock,
    input  wire [7:0] drv_out,
    input  wire [7:0] drv_oe,
    input  wire [7:0] pull,
    input  wire [7:0] ext_val,
    input  wire       ext_on,
    output wire [7:0] pad
);
    logic [7:0] noise = 8'h00;
    // Floating lines change every cycle
    always @(posedge clock) noise <= ~noise;
    // Port drive wins, else outside driver, else pull-up or noise
    assign pad = drv_oe & drv_out | ~drv_oe & (ext_on ? ext_val : pull | noise & ~pull);
endmodule // dbp_pad_model

// ==== dbp_port_lane.v ====
// One 8-bit port: data latch, direction register, pin drivers, read mux.
// Assumes decoded strobes from the top; pads already synchronised.
`timescale 1ns/1ps
`include "dbp_map.vh"
module dbp_port_lane #(
    parameter W = `DBP_PORT_W
) (
    input  wire         clock,
    input  wire         reset_n,
    input  wire         clock_enable,
    input  wire         soft_reset,
    input  wire         data_write,
    input  wire         dir_write,
    input  wire [1:0]   write_op,
    input  wire [2:0]   bit_index,
    input  wire [W-1:0] write_data,
    input  wire [W-1:0] pad_sync,
    output reg  [W-1:0] data_latch,
    output reg  [W-1:0] direction,
    output wire [W-1:0] port_read,
    output reg  [W-1:0] pin_out,
    output reg  [W-1:0] pin_oe
);
    wire [W-1:0] bit_mask;
    reg  [W-1:0] next_data;
    genvar g;

    assign bit_mask = {{(W-1){1'b0}}, 1'b1} << bit_index;

    // Per-bit read source: pad if input, latch if output
    generate
        for (g = 0; g < W; g = g + 1) begin : gen_read
            assign port_read[g] = direction[g] ? pad_sync[g] : data_latch[g]; // [RL6] [RL12]
        end
    endgenerate

    // Modify the whole read image, write back to the latch
    always @* begin
        case (write_op)
            `DBP_OP_WRITE:   next_data = write_data;
            `DBP_OP_SET_BIT: next_data = port_read | bit_mask;   // [RL11] [RL12]
            `DBP_OP_CLR_BIT: next_data = port_read & ~bit_mask;  // [RL11] [RL12]
            `DBP_OP_CPL:     next_data = ~port_read;              // [RL12]
            default:         next_data = write_data;
        endcase
    end

    // Latch and direction hold until rewritten; reset to all ones
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            data_latch <= `DBP_RESET_DATA; // [RL9]
            direction  <= `DBP_RESET_DIR;  // [RL9] [RL10]
        end else if (clock_enable) begin
            if (soft_reset) begin
                data_latch <= `DBP_RESET_DATA; // [RL9]
                direction  <= `DBP_RESET_DIR;  // [RL10]
            end else begin
                if (data_write)
                    data_latch <= next_data; // [RL3]
                if (dir_write)
                    direction <= write_data; // [RL4]
            end
        end
    end

    // Registered push-pull drive, enable is inverse of direction
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            pin_out <= `DBP_RESET_DATA;
            pin_oe  <= {W{1'b0}};
        end else if (clock_enable) begin
            pin_out <= data_latch;  // [RL7]
            pin_oe  <= ~direction;  // [RL5] [RL15]
        end
    end
endmodule // dbp_port_lane

// ==== dbp_sync.v ====
// Two-flop synchroniser for a bus of pad levels.
// Assumes one clock; the first stage feeds only the second.
`timescale 1ns/1ps
module dbp_sync #(
    parameter W = 8
) (
    input  wire         clock,
    input  wire         reset_n,
    input  wire         clock_enable,
    input  wire [W-1:0] async_in,
    output reg  [W-1:0] sync_out
);
    reg [W-1:0] stage_one;

    // Two stages, pads idle high at reset
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            stage_one <= {W{1'b1}};
            sync_out  <= {W{1'b1}};
        end else if (clock_enable) begin
            stage_one <= async_in;
            sync_out  <= stage_one;
        end
    end
endmodule // dbp_sync
